// *** verilog/ecs_pkg.sv ***
// Purpose: shared constants for the discharge counter and serdes
//          auto-negotiation register bank
// Assumes: 50 MHz pclk, apb with 32-bit data, one word per register
// Notes:   register indices are word numbers, byte address is index times four

package ecs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int ADDR_W  = 18;       // byte address width on apb
  localparam int IDX_W   = 16;       // register index width
  localparam int REG_W   = 16;       // width of each register
  localparam int DATA_W  = 32;       // apb data width

  ////////////////////////////////////////////////////////////////////////////
  // register indices
  localparam logic [IDX_W-1:0] IDX_DISCHARGE_COUNTS = 16'h0448;
  localparam logic [IDX_W-1:0] IDX_AN_TIMER_CONFIG  = 16'h0456;
  localparam logic [IDX_W-1:0] IDX_AN_STATUS        = 16'h0459;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS       = 16'h0470;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK         = 16'h0471;

  ////////////////////////////////////////////////////////////////////////////
  // field layout
  localparam int CNT_W          = 6;   // discharge counter width
  localparam int MAC_CNT_LSB    = 8;   // mac interface counter at 13:8
  localparam int LINE_CNT_LSB   = 0;   // line side counter at 5:0
  localparam int TSEL_LSB       = 12;  // timer select at 13:12
  localparam int TSEL_W         = 2;
  localparam int PAGE_RX_BIT    = 1;
  localparam int AN_DONE_BIT    = 0;
  localparam int IRQ_W          = 4;   // interrupt sources
  localparam int IRQ_MAC_BIT    = 0;
  localparam int IRQ_LINE_BIT   = 1;
  localparam int IRQ_PAGE_BIT   = 2;
  localparam int IRQ_DONE_BIT   = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [TSEL_W-1:0] TSEL_RESET     = 2'h1;
  localparam logic [11:0]       TIMER_CFG_LOW  = 12'h008;  // fixed low bits
  localparam logic [REG_W-1:0]  REG_ZERO       = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // timer select codes
  typedef enum logic [TSEL_W-1:0] {
    ECS_TSEL_1P6MS = 2'h0,
    ECS_TSEL_2US   = 2'h1,
    ECS_TSEL_800US = 2'h2,
    ECS_TSEL_11MS  = 2'h3
  } ecs_tsel_t;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_1P6MS_NS    = 1600000;
  localparam int T_2US_NS      = 2000;
  localparam int T_800US_NS    = 800000;
  localparam int T_11MS_NS     = 11000000;
  localparam int TMR_W         = 20;
  localparam int CYC_1P6MS = (T_1P6MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_2US   = (T_2US_NS   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_800US = (T_800US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_11MS  = (T_11MS_NS  + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // timer state
  typedef enum logic [0:0] {
    ECS_TMR_IDLE = 1'b0,
    ECS_TMR_RUN  = 1'b1
  } ecs_tmr_state_t;

endpackage

// *** verilog/ecs_event_counter.sv ***
// Purpose: counter of protection activations that survives hardware reset
// Assumes: hit is synchronous to clk, por_n only falls on power up
// Notes:   wraps from all ones to zero

`timescale 1ns/1ps
`default_nettype none

module ecs_event_counter #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             por_n,
  input  wire logic             hit,
  output logic      [WIDTH-1:0] count
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("ecs_event_counter width must be at least one");
    end
  endgenerate

  logic [WIDTH-1:0] count_q;

  // one step for every cycle the structure is active, no dead time
  // no dead time counting
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      count_q <= '0;
    end else if (hit) begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign count = count_q;

endmodule

`default_nettype wire

// *** verilog/ecs_regs.sv ***
// Purpose: apb register bank with discharge counters, auto-negotiation
//          timer select and auto-negotiation status
// Assumes: all inputs synchronous to pclk; por_n is the power-on reset
// Notes:   discharge counters ignore presetn, only por_n clears them

`timescale 1ns/1ps
`default_nettype none

module ecs_regs #(
  parameter logic [19:0] AN_TMR_1P6MS_CYC = 20'(ecs_pkg::CYC_1P6MS),
  parameter logic [19:0] AN_TMR_800US_CYC = 20'(ecs_pkg::CYC_800US),
  parameter logic [19:0] AN_TMR_11MS_CYC  = 20'(ecs_pkg::CYC_11MS)
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        por_n,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ecs_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ecs_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [ecs_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  // protection activations
  input  wire logic                        mac_discharge_hit,
  input  wire logic                        line_discharge_hit,
  // serdes auto-negotiation
  input  wire logic                        an_page_received,
  input  wire logic                        an_complete,
  input  wire logic                        an_timer_start,
  output logic                             an_timer_done,
  output logic      [ecs_pkg::TSEL_W-1:0]  an_timer_select,
  // interrupt
  output logic                             irq
);

  generate
    if (AN_TMR_1P6MS_CYC == 20'h0_0000 || AN_TMR_800US_CYC == 20'h0_0000 ||
        AN_TMR_11MS_CYC == 20'h0_0000) begin : g_bad_timer
      $error("ecs_regs timer counts must be at least one");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  // the short setting is fixed, only the long ones scale
  localparam logic [19:0] TMR_2US_CYC = 20'(ecs_pkg::CYC_2US);
  localparam logic [19:0] TMR_ONE     = 20'h0_0001;

  logic [ecs_pkg::CNT_W-1:0]  mac_count;
  logic [ecs_pkg::CNT_W-1:0]  line_count;
  logic [ecs_pkg::TSEL_W-1:0] tsel_q;
  logic                       page_q;
  logic                       done_q;
  logic [ecs_pkg::IRQ_W-1:0]  irq_stat_q;
  logic [ecs_pkg::IRQ_W-1:0]  irq_mask_q;
  logic [ecs_pkg::IRQ_W-1:0]  irq_set;
  logic [ecs_pkg::DATA_W-1:0] rdata_q;
  logic                       err_q;
  logic                       setup;
  logic                       access;
  logic                       wr_en;
  logic [ecs_pkg::IDX_W-1:0]  idx;
  logic                       aligned;
  logic                       hit_cnt;
  logic                       hit_tcfg;
  logic                       hit_stat;
  logic                       hit_istat;
  logic                       hit_imask;
  logic                       mapped;
  logic [ecs_pkg::REG_W-1:0]  rd_mux;
  logic [ecs_pkg::REG_W-1:0]  reg_cnt;
  logic [ecs_pkg::REG_W-1:0]  reg_tcfg;
  logic [ecs_pkg::REG_W-1:0]  reg_stat;
  ecs_pkg::ecs_tmr_state_t    tmr_state_q;
  logic [19:0]                tmr_cnt_q;
  logic [19:0]                tmr_limit;
  logic                       tmr_done_q;

  ////////////////////////////////////////////////////////////////////////////
  // discharge counters on the power-on reset

  ecs_event_counter #(
    .WIDTH (ecs_pkg::CNT_W)
  ) u_mac_counter (
    .clk   (pclk),
    .por_n (por_n),
    .hit   (mac_discharge_hit),
    .count (mac_count)
  );

  ecs_event_counter #(
    .WIDTH (ecs_pkg::CNT_W)
  ) u_line_counter (
    .clk   (pclk),
    .por_n (por_n),
    .hit   (line_discharge_hit),
    .count (line_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign idx     = paddr[ecs_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);

  assign hit_cnt   = aligned & (idx == ecs_pkg::IDX_DISCHARGE_COUNTS);
  assign hit_tcfg  = aligned & (idx == ecs_pkg::IDX_AN_TIMER_CONFIG);
  assign hit_stat  = aligned & (idx == ecs_pkg::IDX_AN_STATUS);
  assign hit_istat = aligned & (idx == ecs_pkg::IDX_IRQ_STATUS);
  assign hit_imask = aligned & (idx == ecs_pkg::IDX_IRQ_MASK);
  assign mapped    = hit_cnt | hit_tcfg | hit_stat | hit_istat | hit_imask;

  // write lands only in the access cycle of a mapped address
  assign wr_en = access & pwrite & ~err_q;

  ////////////////////////////////////////////////////////////////////////////
  // read images
  always_comb begin
    reg_cnt = ecs_pkg::REG_ZERO;
    reg_cnt[ecs_pkg::MAC_CNT_LSB +: ecs_pkg::CNT_W]  = mac_count;
    reg_cnt[ecs_pkg::LINE_CNT_LSB +: ecs_pkg::CNT_W] = line_count;
  end

  always_comb begin
    reg_tcfg = ecs_pkg::REG_ZERO;
    reg_tcfg[ecs_pkg::TSEL_LSB +: ecs_pkg::TSEL_W] = tsel_q;
    reg_tcfg[ecs_pkg::TSEL_LSB-1:0] = ecs_pkg::TIMER_CFG_LOW;   // fixed read-only bits
  end

  always_comb begin
    reg_stat = ecs_pkg::REG_ZERO;
    reg_stat[ecs_pkg::PAGE_RX_BIT] = page_q;
    reg_stat[ecs_pkg::AN_DONE_BIT] = done_q;
  end

  // read multiplexer, unmapped reads give zero
  always_comb begin
    rd_mux = ecs_pkg::REG_ZERO;
    if (hit_cnt) begin
      rd_mux = reg_cnt;
    end else if (hit_tcfg) begin
      rd_mux = reg_tcfg;
    end else if (hit_stat) begin
      rd_mux = reg_stat;
    end else if (hit_istat) begin
      rd_mux = {{(ecs_pkg::REG_W-ecs_pkg::IRQ_W){1'b0}}, irq_stat_q};
    end else if (hit_imask) begin
      rd_mux = {{(ecs_pkg::REG_W-ecs_pkg::IRQ_W){1'b0}}, irq_mask_q};
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= {{(ecs_pkg::DATA_W-ecs_pkg::REG_W){1'b0}}, rd_mux};
      err_q   <= ~mapped;
    end
  end

  // zero wait states: ready in every access cycle
  assign pready  = access;
  assign pslverr = access & err_q;
  assign prdata  = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // timer select field

  // writable select, resets to 2 us code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsel_q <= ecs_pkg::TSEL_RESET;
    end else if (wr_en && hit_tcfg && pstrb[1]) begin
      tsel_q <= pwdata[ecs_pkg::TSEL_LSB +: ecs_pkg::TSEL_W];
    end
  end

  // select code is also offered to the serdes side
  assign an_timer_select = tsel_q;

  always_comb begin
    case (ecs_pkg::ecs_tsel_t'(tsel_q))
      ecs_pkg::ECS_TSEL_1P6MS: tmr_limit = AN_TMR_1P6MS_CYC;
      ecs_pkg::ECS_TSEL_2US:   tmr_limit = TMR_2US_CYC;
      ecs_pkg::ECS_TSEL_800US: tmr_limit = AN_TMR_800US_CYC;
      ecs_pkg::ECS_TSEL_11MS:  tmr_limit = AN_TMR_11MS_CYC;
      default:                 tmr_limit = TMR_2US_CYC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // negotiation timer: start pulse arms it, done pulses once at expiry

  // timer runs for the selected count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_state_q <= ecs_pkg::ECS_TMR_IDLE;
      tmr_cnt_q   <= '0;
      tmr_done_q  <= 1'b0;
    end else begin
      tmr_done_q <= 1'b0;
      case (tmr_state_q)
        ecs_pkg::ECS_TMR_IDLE: begin
          if (an_timer_start) begin
            tmr_state_q <= ecs_pkg::ECS_TMR_RUN;
            tmr_cnt_q   <= TMR_ONE;
          end
        end
        ecs_pkg::ECS_TMR_RUN: begin
          if (an_timer_start) begin
            tmr_cnt_q <= TMR_ONE;             // restart
          end else if (tmr_cnt_q >= tmr_limit) begin
            tmr_state_q <= ecs_pkg::ECS_TMR_IDLE;
            tmr_done_q  <= 1'b1;
          end else begin
            tmr_cnt_q <= tmr_cnt_q + TMR_ONE;
          end
        end
        default: begin
          tmr_state_q <= ecs_pkg::ECS_TMR_IDLE;
        end
      endcase
    end
  end

  // one-cycle expiry pulse from a flop
  assign an_timer_done = tmr_done_q;

  ////////////////////////////////////////////////////////////////////////////
  // negotiation status sampling

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      page_q <= an_page_received;
      done_q <= an_complete;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write one to clear, set wins
  always_comb begin
    irq_set = '0;
    irq_set[ecs_pkg::IRQ_MAC_BIT]  = mac_discharge_hit;
    irq_set[ecs_pkg::IRQ_LINE_BIT] = line_discharge_hit;
    irq_set[ecs_pkg::IRQ_PAGE_BIT] = an_page_received & ~page_q;
    irq_set[ecs_pkg::IRQ_DONE_BIT] = an_complete & ~done_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (wr_en && hit_istat && pstrb[0]) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[ecs_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // mask register, one enables the source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (wr_en && hit_imask && pstrb[0]) begin
      irq_mask_q <= pwdata[ecs_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

endmodule

`default_nettype wire

// *** bench/ecs_regs_checker.sv ***
// Purpose: port assertions for the register bank
// Assumes: one pclk domain, presetn gates checking
// Notes:   counts mirrored here, cleared by por_n only
`timescale 1ns/1ps
`default_nettype none
module ecs_regs_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        por_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        mac_discharge_hit,
  input wire logic        line_discharge_hit,
  input wire logic        an_page_received,
  input wire logic        an_complete,
  input wire logic        an_timer_start,
  input wire logic        an_timer_done,
  input wire logic [1:0]  an_timer_select
);
  localparam logic [17:0] A_CNT = {ecs_pkg::IDX_DISCHARGE_COUNTS, 2'h0};
  localparam logic [17:0] A_CFG = {ecs_pkg::IDX_AN_TIMER_CONFIG, 2'h0};
  localparam logic [17:0] A_STA = {ecs_pkg::IDX_AN_STATUS, 2'h0};
  logic [5:0] mac_m_q;
  logic [5:0] line_m_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mirror counts, untouched by presetn
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      mac_m_q  <= 6'h00;
      line_m_q <= 6'h00;
    end else begin
      mac_m_q  <= mac_m_q + {5'h00, mac_discharge_hit};
      line_m_q <= line_m_q + {5'h00, line_discharge_hit};
    end
  end
  // access phase of a read or a select write
  sequence rd(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence wr_sel;
    psel && penable && pwrite && paddr == A_CFG && pstrb[1];
  endsequence
  cnt_mac_a: assert property (rd(A_CNT) |-> prdata[13:8] == $past(mac_m_q))
    else $error("mac count mismatch");
  cnt_line_a: assert property (rd(A_CNT) |-> prdata[5:0] == $past(line_m_q))
    else $error("line count mismatch");
  tsel_wr_a: assert property (wr_sel |=> an_timer_select == $past(pwdata[13:12]))
    else $error("select not written");
  tsel_rst_a: assert property ($rose(presetn) |-> an_timer_select == ecs_pkg::TSEL_RESET)
    else $error("select reset value");
  cfg_low_a: assert property (rd(A_CFG) |-> prdata[11:0] == ecs_pkg::TIMER_CFG_LOW)
    else $error("timer config low bits");
  tmr_done_a: assert property (an_timer_start && an_timer_select == 2'h1 |-> ##101 an_timer_done)
    else $error("short timer late");
  page_rd_a: assert property (rd(A_STA) |-> prdata[1] == $past(an_page_received, 2))
    else $error("page status wrong");
  done_rd_a: assert property (rd(A_STA) |-> prdata[0] == $past(an_complete, 2))
    else $error("complete status wrong");
endmodule
bind ecs_regs ecs_regs_checker u_chk (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .mac_discharge_hit, .line_discharge_hit, .an_page_received, .an_complete,
  .an_timer_start, .an_timer_done, .an_timer_select);
`default_nettype wire

// *** bench/ecs_mac_model.sv ***
// Purpose: far side serdes partner for negotiation
// Assumes: go is a one-cycle request
// Notes:   slow adds five idle cycles before the page
`timescale 1ns/1ps
`default_nettype none
module ecs_mac_model (
  input  wire logic pclk,
  input  wire logic rst_n,
  input  wire logic go,
  input  wire logic slow,
  input  wire logic timer_done,
  output logic      page,
  output logic      complete,
  output logic      timer_start
);
  logic       busy_q;
  logic       armed_q;
  logic [2:0] wait_q;
  // start the timer, then report page and completion
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      page        <= 1'b0;
      complete    <= 1'b0;
      timer_start <= 1'b0;
      busy_q      <= 1'b0;
      armed_q     <= 1'b0;
      wait_q      <= 3'h0;
    end else begin
      timer_start <= go;
      if (go) begin
        busy_q   <= 1'b1;
        page     <= 1'b0;
        complete <= 1'b0;
        wait_q   <= slow ? 3'h5 : 3'h0;
      end else if (busy_q && timer_done) begin
        busy_q  <= 1'b0;
        armed_q <= 1'b1;
      end else if (armed_q) begin
        if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
        else if (!page) page <= 1'b1;
        else begin
          complete <= 1'b1;
          armed_q  <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Purpose: self-checking bench for the register bank
// Assumes: zero wait apb, short timer limits 20 10 30
// Notes:   random hit patterns from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [17:0] A_CNT = {ecs_pkg::IDX_DISCHARGE_COUNTS, 2'h0};
  localparam logic [17:0] A_CFG = {ecs_pkg::IDX_AN_TIMER_CONFIG, 2'h0};
  localparam logic [17:0] A_STA = {ecs_pkg::IDX_AN_STATUS, 2'h0};
  localparam logic [17:0] A_IST = {ecs_pkg::IDX_IRQ_STATUS, 2'h0};
  localparam logic [17:0] A_IMK = {ecs_pkg::IDX_IRQ_MASK, 2'h0};
  localparam logic [19:0] T_LONG = 20'h0_0014;  // shortened timer counts
  localparam logic [19:0] T_MID  = 20'h0_000A;
  localparam logic [19:0] T_MAX  = 20'h0_001E;
  logic        pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, slow = 0;
  logic        mac_discharge_hit = 0, line_discharge_hit = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d;
  logic [3:0]  pstrb = 0;
  logic [5:0]  em = 0, el = 0;
  logic [1:0]  an_timer_select;
  logic        pready, pslverr, an_page_received, an_complete, an_timer_start, an_timer_done, irq, e;
  int          n_errors = 0, check_count = 0, n;
  ecs_regs #(.AN_TMR_1P6MS_CYC(T_LONG), .AN_TMR_800US_CYC(T_MID), .AN_TMR_11MS_CYC(T_MAX)) dut (
    .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .mac_discharge_hit, .line_discharge_hit, .an_page_received, .an_complete,
    .an_timer_start, .an_timer_done, .an_timer_select, .irq);
  ecs_mac_model u_mac (.pclk, .rst_n(presetn), .go, .slow, .timer_done(an_timer_done),
    .page(an_page_received), .complete(an_complete), .timer_start(an_timer_start));
  always #10 pclk = ~pclk;
  // verdict
  task automatic stop_test;
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, s, x);
    end
  endtask
  // one apb transfer, result in d and e
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] wd, input logic [3:0] s);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // access phase lasts until the slave answers, watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // random activations, expected counts wrap at six bits
  task automatic hits(input int c);
    logic m, l;
    repeat (c) begin
      @(posedge pclk);
      m = 1'($urandom);
      l = 1'($urandom);
      mac_discharge_hit  <= m;
      line_discharge_hit <= l;
      em += {5'h00, m};
      el += {5'h00, l};
    end
    @(posedge pclk);
    mac_discharge_hit  <= 1'b0;
    line_discharge_hit <= 1'b0;
  endtask
  function automatic int tmr_n(input int c);
    return c == 0 ? int'(T_LONG) : c == 1 ? ecs_pkg::CYC_2US : c == 2 ? int'(T_MID) : int'(T_MAX);
  endfunction
  initial begin
    #100us;
    n_errors++;
    stop_test;
  end
  initial begin
    void'($urandom(80431));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    apb(1'b0, A_CFG, 32'h0, 4'h0);
    chk(d, 32'h0000_1008);
    chk({30'h0, an_timer_select}, 32'h1);
    apb(1'b0, A_STA, 32'h0, 4'h0);
    chk(d, 32'h0);
    apb(1'b1, 18'h0_0004, 32'hFFFF_FFFF, 4'hF);
    chk({31'h0, e}, 32'h1);
    hits(150);
    apb(1'b0, A_CNT, 32'h0, 4'h0);
    chk(d, {18'h0, em, 2'h0, el});
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, A_IMK, 32'h1, 4'h1);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, A_IST, 32'h1, 4'h1);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CNT, 32'h0, 4'h0);
    chk(d, {18'h0, em, 2'h0, el});
    presetn <= 1'b0;
    por_n   <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    apb(1'b0, A_CNT, 32'h0, 4'h0);
    chk(d, 32'h0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_CFG, 32'(c) << 12, 4'h2);
      apb(1'b1, A_CFG, (32'(c) << 12) ^ 32'h0000_3000, 4'hD);
      chk({30'h0, an_timer_select}, 32'(c));
      slow <= c[0];
      go   <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      do @(posedge pclk); while (an_timer_start !== 1'b1);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (an_timer_done !== 1'b1 && n < 700);
      chk(n, tmr_n(c) + 1);
      repeat (10) @(posedge pclk);
      apb(1'b0, A_STA, 32'h0, 4'h0);
      chk(d, 32'h3);
    end
    apb(1'b1, A_IMK, 32'hC, 4'h1);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, A_IST, 32'hF, 4'h1);
    apb(1'b0, A_IST, 32'h0, 4'h0);
    chk(d, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, A_IMK, 32'h0, 4'h0);
    chk(d, 32'h0000_000C);
    apb(1'b0, A_CNT | 18'h0_0002, 32'h0, 4'h0);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    stop_test;
  end
endmodule
`default_nettype wire
